// ==== include/omc_consts.svh ====
// constants of the operating mode controller: offsets, fields, resets, timing
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define OMC_AXI_AW        8
`define OMC_OFS_CTRL      8'h00
`define OMC_OFS_STATUS    8'h04
`define OMC_CTRL_RST      2'h3
`define OMC_RESP_OKAY     2'h0
`define OMC_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define OMC_ST_MODE_LSB   0
`define OMC_ST_WD_LSB     8
`define OMC_ST_FC_LSB     12
`define OMC_ST_REFRESH    16
`define OMC_ST_LASTOT     17
`define OMC_ST_WDOSENSE   18

// ----------------------------------------------------------------------------
// counts and timing
// ----------------------------------------------------------------------------
`define OMC_FAIL_LIMIT    3'h4
`define OMC_CLK_KHZ       32'd50000
`define OMC_REFRESH_MS    32'd100
`define OMC_OVERTEMP_SHUTDOWN_REFR_S   32'd30
`define OMC_REFRESH_CYC   (`OMC_REFRESH_MS * `OMC_CLK_KHZ)
`define OMC_OVERTEMP_SHUTDOWN_CYC      (`OMC_OVERTEMP_SHUTDOWN_REFR_S * 32'd1000 * `OMC_CLK_KHZ)

`endif

// ==== include/omc_pkg.sv ====
// types of the operating mode controller
// assumes omc_consts.svh on the include path
`include "omc_consts.svh"

package omc_pkg;

  // --------------------------------------------------------------------------
  // modes
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    OMC_OFF    = 6'h01,
    OMC_ACTIVE = 6'h02,
    OMC_DEV    = 6'h04,
    OMC_LOWP   = 6'h08,
    OMC_SAFE   = 6'h10,
    OMC_LATCH  = 6'h20
  } omc_mode_t;

  // --------------------------------------------------------------------------
  // pin inputs and rail controls
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ignitionRequest;
    logic supplyAboveStart;
    logic supplyOver;
    logic supplyUnder;
    logic overtempShutdown;
    logic pumpUndervoltage;
    logic load1LowCompare;
    logic load1HighCompare;
    logic load2LowCompare;
    logic load2HighCompare;
    logic devEnterThreshold;
    logic devExitThreshold;
    logic lowPowerRequest;
    logic watchdogFaultSense;
  } omc_pins_t;

  typedef struct packed {
    logic stage1Enable;
    logic stage2Enable;
    logic stage1Bypass;
    logic stage2Bypass;
    logic converterLdoEnable;
    logic watchdogEnable;
    logic monitorEnable;
    logic pumpEnable;
    logic powerUpStart;
  } omc_rails_t;

  // --------------------------------------------------------------------------
  // whole state of the controller
  // --------------------------------------------------------------------------
  typedef struct packed {
    omc_mode_t              mode;
    omc_pins_t              sy1;
    omc_pins_t              sy2;
    omc_pins_t              sy3;
    omc_pins_t              flt;
    logic [2:0]             wdCount;
    logic [2:0]             fcCount;
    logic                   refreshOn;
    logic                   lastOtsd;
    logic [31:0]            refreshTimer;
    omc_rails_t             rails;
    logic                   wdoOeN;
    logic [1:0]             regEnable;
    logic                   awHeld;
    logic                   wHeld;
    logic [`OMC_AXI_AW-1:0] awAddr;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } omc_state_t;

endpackage : omc_pkg

// ==== rtl/omc_mode_ctrl.sv ====
// operating mode state machine of a multi-regulator supply device
// assumes comparator and fault levels arrive asynchronously on pins, the
// watchdog unit shares clk_sys, and software uses AXI4-Lite
//
// Overview of operation
// - OFF goes ACTIVE when supply is above start level and ignition request is high.
// - each entry to ACTIVE from OFF or SAFE pulses the regulator power-up start.
// - window pin above enter level: developer mode, watchdog off; below exit: ACTIVE.
// - low power: converter LDO off, regulators bypassed, watchdog and monitoring off.
// - low power is entered only from ACTIVE on the low-power request input.
// - only regulator one: enter on its load-low, leave on its load-high comparator.
// - only regulator two: enter on its load-low, leave on its load-high comparator.
// - both regulators: use regulator one comparators only, both bypasses on.
// - overtemp, supply over/under voltage or pump undervoltage sends ACTIVE to SAFE.
// - SAFE: outputs and watchdog off, monitoring and charge pump on.
// - SAFE is left for ACTIVE only when every failure condition has cleared.
// - LATCH is left only through OFF; otherwise it holds forever.
// - LATCH: everything off and the watchdog fault output driven low.
// - watchdog and thermal/pump failure counters; either reaching 4 latches.
// - each watchdog failure in ACTIVE with no failure condition present adds one to the watchdog failure counter.
// - watchdog counter clears on correct service and in OFF, developer, low power.
// - thermal or pump failure goes SAFE and counts up the thermal/pump counter.
// - on clearing, return ACTIVE, rerun power-up and start the refresh timer.
// - a recurrence inside the refresh interval goes SAFE and counts again.
// - no failure for 100 ms of ACTIVE time, or 30 s of it after overtemp, clears the counter.
`timescale 1ns/100ps
`include "omc_consts.svh"

module omc_mode_ctrl #(
  parameter logic [31:0] REFRESH_CYCLES = `OMC_REFRESH_CYC,
  parameter logic [31:0] OVERTEMP_SHUTDOWN_CYCLES    = `OMC_OVERTEMP_SHUTDOWN_CYC
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // pins and comparators
  input  wire omc_pkg::omc_pins_t     pinsIn,
  // watchdog unit
  input  wire logic                   wdFailPulse,
  input  wire logic                   wdServedPulse,
  input  wire logic                   wdFaultDrive,
  // regulator and monitor controls
  output logic                        wdoOut,
  output logic                        wdoOeN,
  output omc_pkg::omc_rails_t         rails,
  // axi4-lite write
  input  wire logic [`OMC_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [`OMC_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import omc_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  omc_state_t st_reg;
  omc_state_t st_next;
  logic       faultAny;
  logic       hardFault;
  logic       lpEnter;
  logic       lpExit;
  logic [31:0] refreshLimit;

  // bit 0 control word, bit 1 status word
  function automatic logic [1:0] omcDecode(input logic [`OMC_AXI_AW-1:0] a);
    omcDecode = {a == `OMC_OFS_STATUS, a == `OMC_OFS_CTRL};
  endfunction : omcDecode

  // --------------------------------------------------------------------------
  // decoded conditions
  // --------------------------------------------------------------------------
  always_comb begin
    faultAny  = st_reg.flt.overtempShutdown | st_reg.flt.supplyOver |
                st_reg.flt.supplyUnder | st_reg.flt.pumpUndervoltage;
    hardFault = st_reg.flt.overtempShutdown | st_reg.flt.pumpUndervoltage;
    // regulator one comparators whenever it is enabled
    if (st_reg.regEnable[0]) begin
      lpEnter = st_reg.flt.lowPowerRequest & st_reg.flt.load1LowCompare;
      lpExit  = st_reg.flt.load1HighCompare;
    end else begin
      lpEnter = st_reg.flt.lowPowerRequest & st_reg.regEnable[1] &
                st_reg.flt.load2LowCompare;
      lpExit  = st_reg.flt.load2HighCompare;
    end
    lpExit = lpExit | ~st_reg.flt.lowPowerRequest;
    refreshLimit = st_reg.lastOtsd ? OVERTEMP_SHUTDOWN_CYCLES : REFRESH_CYCLES;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rails.powerUpStart = 1'b0;

    // pin synchronisers: a change counts once stages two and three agree
    st_next.sy1 = pinsIn;
    st_next.sy2 = st_reg.sy1;
    st_next.sy3 = st_reg.sy2;
    for (int i = 0; i < $bits(omc_pins_t); i++) begin
      if (st_reg.sy2[i] == st_reg.sy3[i]) begin
        st_next.flt[i] = st_reg.sy3[i];
      end
    end

    unique case (st_reg.mode)
      OMC_OFF: begin
        st_next.wdCount   = 3'h0;
        st_next.fcCount   = 3'h0;
        st_next.refreshOn = 1'b0;
        if (st_reg.flt.ignitionRequest && st_reg.flt.supplyAboveStart) begin
          st_next.mode               = OMC_ACTIVE;
          st_next.rails.powerUpStart = 1'b1;
        end
      end
      OMC_ACTIVE, OMC_DEV: begin
        if (st_reg.mode == OMC_DEV) begin
          st_next.wdCount = 3'h0;
        end
        if (faultAny) begin
          st_next.mode = OMC_SAFE;
          if (hardFault) begin
            st_next.fcCount   = st_reg.fcCount + 3'h1;
            st_next.lastOtsd  = st_reg.flt.overtempShutdown;
            st_next.refreshOn = 1'b0;
            if (st_next.fcCount >= `OMC_FAIL_LIMIT) begin
              st_next.mode = OMC_LATCH;
            end
          end
        end else if (st_reg.mode == OMC_ACTIVE) begin
          if (st_reg.refreshOn) begin
            st_next.refreshTimer = st_reg.refreshTimer + 32'h1;
            if (st_next.refreshTimer >= refreshLimit) begin
              st_next.fcCount   = 3'h0;
              st_next.refreshOn = 1'b0;
            end
          end
          if (st_reg.flt.devEnterThreshold) begin
            st_next.mode = OMC_DEV;
          end else if (lpEnter) begin
            st_next.mode = OMC_LOWP;
          end
          // a failure in the same cycle as a service still counts
          if (wdFailPulse) begin
            st_next.wdCount = st_reg.wdCount + 3'h1;
            if (st_next.wdCount >= `OMC_FAIL_LIMIT) begin
              st_next.mode = OMC_LATCH;
            end
          end else if (wdServedPulse) begin
            st_next.wdCount = 3'h0;
          end
        end else if (st_reg.flt.devExitThreshold) begin
          st_next.mode = OMC_ACTIVE;
        end
      end
      OMC_LOWP: begin
        st_next.wdCount = 3'h0;
        if (lpExit) begin
          st_next.mode = OMC_ACTIVE;
        end
      end
      OMC_SAFE: begin
        if (!faultAny) begin
          st_next.mode               = OMC_ACTIVE;
          st_next.rails.powerUpStart = 1'b1;
          st_next.refreshOn          = 1'b1;
          st_next.refreshTimer       = 32'h0;
        end
      end
      OMC_LATCH: begin
        st_next.mode = OMC_LATCH;
      end
    endcase

    // losing the ignition request is the only exit from latch
    if (!st_reg.flt.ignitionRequest) begin
      st_next.mode               = OMC_OFF;
      st_next.rails.powerUpStart = 1'b0;
      // a count that reached the limit this cycle must not linger outside latch
      st_next.wdCount            = 3'h0;
      st_next.fcCount            = 3'h0;
    end

    // rail controls follow the mode being entered
    st_next.rails.converterLdoEnable = st_next.mode inside {OMC_ACTIVE, OMC_DEV};
    st_next.rails.watchdogEnable     = st_next.mode == OMC_ACTIVE;
    st_next.rails.monitorEnable =
      st_next.mode inside {OMC_ACTIVE, OMC_DEV, OMC_SAFE};
    st_next.rails.pumpEnable =
      st_next.mode inside {OMC_ACTIVE, OMC_DEV, OMC_LOWP, OMC_SAFE};
    st_next.wdoOeN = ~((st_next.mode == OMC_LATCH) | wdFaultDrive);

    // axi write: address and data in either order, response after both
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.wHeld = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_next.awHeld && st_next.wHeld && !st_reg.bvalid) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `OMC_RESP_SLVERR;
      if (omcDecode(st_next.awAddr) == 2'h1) begin
        st_next.bresp = `OMC_RESP_OKAY;
        if (st_next.wStrb[0]) begin
          st_next.regEnable = st_next.wData[1:0];
        end
      end else if (omcDecode(st_next.awAddr) == 2'h2) begin
        st_next.bresp = `OMC_RESP_OKAY;
      end
    end
    st_next.awready = ~st_next.awHeld & ~st_next.bvalid;
    st_next.wready  = ~st_next.wHeld & ~st_next.bvalid;

    // stage controls use the enables being written, so bypass stays in step
    st_next.rails.stage1Enable = st_next.regEnable[0] &
      (st_next.mode inside {OMC_ACTIVE, OMC_DEV, OMC_LOWP});
    st_next.rails.stage2Enable = st_next.regEnable[1] &
      (st_next.mode inside {OMC_ACTIVE, OMC_DEV, OMC_LOWP});
    st_next.rails.stage1Bypass = st_next.regEnable[0] & (st_next.mode == OMC_LOWP);
    st_next.rails.stage2Bypass = st_next.regEnable[1] & (st_next.mode == OMC_LOWP);

    // axi read
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = 32'h0;
      st_next.rresp  = `OMC_RESP_OKAY;
      if (omcDecode(s_axi_araddr) == 2'h1) begin
        st_next.rdata[1:0] = st_reg.regEnable;
      end else if (omcDecode(s_axi_araddr) == 2'h2) begin
        st_next.rdata[`OMC_ST_MODE_LSB +: 6] = st_reg.mode;
        st_next.rdata[`OMC_ST_WD_LSB +: 3]   = st_reg.wdCount;
        st_next.rdata[`OMC_ST_FC_LSB +: 3]   = st_reg.fcCount;
        st_next.rdata[`OMC_ST_REFRESH]       = st_reg.refreshOn;
        st_next.rdata[`OMC_ST_LASTOT]        = st_reg.lastOtsd;
        st_next.rdata[`OMC_ST_WDOSENSE]      = st_reg.flt.watchdogFaultSense;
      end else begin
        st_next.rresp = `OMC_RESP_SLVERR;
      end
    end
    st_next.arready = ~st_next.rvalid;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.mode      <= OMC_OFF;
      st_reg.regEnable <= `OMC_CTRL_RST;
      st_reg.wdoOeN    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign wdoOut        = 1'b0;
  assign wdoOeN        = st_reg.wdoOeN;
  assign rails         = st_reg.rails;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_wake_start;
    st_reg.mode == OMC_OFF && st_reg.flt.ignitionRequest && st_reg.flt.supplyAboveStart
      |=> st_reg.mode == OMC_ACTIVE && st_reg.rails.powerUpStart;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("off did not start active");

  property p_power_up;
    st_reg.rails.powerUpStart |-> st_reg.mode == OMC_ACTIVE &&
      ($past(st_reg.mode) == OMC_OFF || $past(st_reg.mode) == OMC_SAFE);
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up start outside entry to active");

  property p_dev_mode;
    st_reg.mode == OMC_DEV |-> !st_reg.rails.watchdogEnable && st_reg.rails.monitorEnable;
  endproperty
  a_dev_mode: assert property (p_dev_mode)
    else $error("developer mode controls wrong");

  property p_lowp_rails;
    st_reg.mode == OMC_LOWP |-> !st_reg.rails.converterLdoEnable &&
      !st_reg.rails.watchdogEnable && !st_reg.rails.monitorEnable &&
      st_reg.rails.stage1Bypass == st_reg.regEnable[0];
  endproperty
  a_lowp_rails: assert property (p_lowp_rails)
    else $error("low power controls wrong");

  property p_lowp_entry;
    st_reg.mode == OMC_LOWP && !$past(st_reg.mode == OMC_LOWP) |-> $past(st_reg.mode == OMC_ACTIVE);
  endproperty
  a_lowp_entry: assert property (p_lowp_entry)
    else $error("low power entered from wrong mode");

  property p_safe_entry;
    st_reg.mode == OMC_ACTIVE && st_reg.flt.supplyOver && st_reg.flt.ignitionRequest
      |=> st_reg.mode inside {OMC_SAFE, OMC_LATCH};
  endproperty
  a_safe_entry: assert property (p_safe_entry)
    else $error("supply overvoltage did not leave active");

  property p_safe_hold;
    st_reg.mode == OMC_SAFE && faultAny && st_reg.flt.ignitionRequest
      |=> st_reg.mode == OMC_SAFE;
  endproperty
  a_safe_hold: assert property (p_safe_hold)
    else $error("safe left with failure present");

  property p_latch_hold;
    st_reg.mode == OMC_LATCH |=> st_reg.mode inside {OMC_LATCH, OMC_OFF};
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch left other than to off");

  property p_latch_rails;
    st_reg.mode == OMC_LATCH |-> !st_reg.wdoOeN && !st_reg.rails.pumpEnable &&
      !st_reg.rails.stage1Enable && !st_reg.rails.monitorEnable;
  endproperty
  a_latch_rails: assert property (p_latch_rails)
    else $error("latch controls wrong");

  property p_count_limit;
    st_reg.mode != OMC_LATCH |-> st_reg.wdCount < 3'h4 && st_reg.fcCount < 3'h4;
  endproperty
  a_count_limit: assert property (p_count_limit)
    else $error("failure count at limit without latch");

endmodule : omc_mode_ctrl

// ==== dv/omc_pin_model.sv ====
// far-side model: open-drain fault pin with its pull-up
// assumes the controller splits the pin into data and low-active enable
`timescale 1ns/100ps
module omc_pin_model (
  // controller side
  input  wire logic wdoOut,
  input  wire logic wdoOeN,
  // resolved pin level
  output logic      faultPin
);
  // a released pin rises to the pull-up level
  assign faultPin = wdoOeN ? 1'b1 : wdoOut;
endmodule : omc_pin_model

// ==== dv/test_omc_mode_ctrl.sv ====
// bench of the operating mode controller: pins, watchdog pulses, axi4-lite
// assumes omc_pkg, omc_mode_ctrl and omc_pin_model; refresh counts shortened
`timescale 1ns/100ps
module test_omc_mode_ctrl;
  import omc_pkg::*;
  logic clk_sys, rst_n, wdFailPulse, wdServedPulse, wdFaultDrive, wdoOut, wdoOeN, fPin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb, faults;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  omc_pins_t pinsIn, pd;
  omc_rails_t rails;
  int n_fail, tests_run, cyc, ups, w, u;
  omc_mode_ctrl #(.REFRESH_CYCLES(32'd20), .OVERTEMP_SHUTDOWN_CYCLES(32'd50)) omc_mode_ctrl_inst (
    .clk_sys, .rst_n, .pinsIn, .wdFailPulse, .wdServedPulse, .wdFaultDrive, .wdoOut, .wdoOeN,
    .rails, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  omc_pin_model omc_pin_model_inst (.wdoOut, .wdoOeN, .faultPin(fPin));
  always_comb begin
    pinsIn = pd;
    {pinsIn.supplyOver, pinsIn.supplyUnder, pinsIn.overtempShutdown} = faults[3:1];
    pinsIn.pumpUndervoltage = faults[0];
    pinsIn.watchdogFaultSense = fPin;
  end
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rails.powerUpStart === 1'b1) ups <= ups + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    st = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd
  task automatic waitMode(input logic [5:0] m);
    w = 0;
    do begin
      rd(8'h04);
      w++;
    end while (st[5:0] !== m && w < 12);
    check(st[5:0], m);
  endtask : waitMode
  // let a pin change pass its synchronisers before judging the mode
  task automatic stay(input logic [5:0] m);
    repeat (8) @(posedge clk_sys);
    waitMode(m);
  endtask : stay
  task automatic wdPulse(input logic served);
    @(posedge clk_sys);
    {wdServedPulse, wdFailPulse} <= {served, ~served};
    @(posedge clk_sys);
    {wdServedPulse, wdFailPulse} <= 2'h0;
  endtask : wdPulse
  task automatic devMode(input logic on);
    {pd.devEnterThreshold, pd.devExitThreshold} <= {on, ~on};
    waitMode(on ? OMC_DEV : OMC_ACTIVE);
  endtask : devMode
  task automatic latchOut();
    check(rails[8:1] & 8'hc7, 8'h00);
    check({wdoOut, wdoOeN}, 2'h0);
    stay(OMC_LATCH);
    check(st[18], 1'b0);
    pd.ignitionRequest <= 1'b0;
    waitMode(OMC_OFF);
    pd.ignitionRequest <= 1'b1;
    waitMode(OMC_ACTIVE);
    check(st[14:8], 7'h00);
  endtask : latchOut
  task automatic testStart();
    rd(8'h00);
    check({st[1:0], rr}, 4'hc);
    rd(8'h08);
    check(st, 32'h0);
    check(rr, 2'h2);
    wr(8'h08, 32'h0, 2'h2);
    pd.ignitionRequest <= 1'b1;
    stay(OMC_OFF);
    pd.supplyAboveStart <= 1'b1;
    waitMode(OMC_ACTIVE);
    check(ups, 1);
    wdFaultDrive <= 1'b1;
    stay(OMC_ACTIVE);
    check({wdoOut, wdoOeN, st[18]}, 3'h0);
    wdFaultDrive <= 1'b0;
    stay(OMC_ACTIVE);
    check({wdoOeN, st[18]}, 2'h3);
  endtask : testStart
  task automatic testDevWd();
    repeat (3) wdPulse(1'b0);
    rd(8'h04);
    check(st[10:8], 3'h3);
    wdPulse(1'b1);
    rd(8'h04);
    check(st[10:8], 3'h0);
    repeat (2) wdPulse(1'b0);
    devMode(1'b1);
    check(st[10:8], 3'h0);
    check(rails[8:1] & 8'h84, 8'h80);
    {pd.lowPowerRequest, pd.load1LowCompare} <= 2'h3;
    stay(OMC_DEV);
    {pd.lowPowerRequest, pd.load1LowCompare} <= 2'h0;
    devMode(1'b0);
    check(ups, 1);
    repeat (4) wdPulse(1'b0);
    waitMode(OMC_LATCH);
    latchOut();
  endtask : testDevWd
  task automatic testLowPower(input logic [1:0] en);
    wr(8'h00, {30'h0, en}, 2'h0);
    pd.lowPowerRequest <= 1'b1;
    {pd.load1LowCompare, pd.load2LowCompare} <= {en == 2'h2, en != 2'h2};
    stay(OMC_ACTIVE);
    {pd.load1LowCompare, pd.load2LowCompare} <= {en != 2'h2, en == 2'h2};
    waitMode(OMC_LOWP);
    check(rails[8:1] & {2'h0, en[0], en[1], 4'he}, {2'h0, en[0], en[1], 4'h0});
    {pd.load1LowCompare, pd.load2LowCompare} <= 2'h0;
    {pd.load1HighCompare, pd.load2HighCompare} <= {en != 2'h2, en == 2'h2};
    waitMode(OMC_ACTIVE);
    {pd.load1HighCompare, pd.load2HighCompare} <= 2'h0;
    {pd.load1LowCompare, pd.load2LowCompare} <= {en != 2'h2, en == 2'h2};
    waitMode(OMC_LOWP);
    pd.lowPowerRequest <= 1'b0;
    waitMode(OMC_ACTIVE);
    {pd.load1LowCompare, pd.load2LowCompare} <= 2'h0;
  endtask : testLowPower
  task automatic testSafe();
    for (int i = 3; i >= 0; i--) begin
      u = ups;
      faults <= 4'h1 << i;
      waitMode(OMC_SAFE);
      check(rails[8:1] & 8'hc7, 8'h03);
      check(st[14:12], i < 2);
      if (i == 3) faults <= 4'h4;
      stay(OMC_SAFE);
      faults <= 4'h0;
      waitMode(OMC_ACTIVE);
      check(ups, u + 1);
      if (i < 2) check(st[16], 1'b1);
      repeat (30) @(posedge clk_sys);
      rd(8'h04);
      check(st[14:12], i == 1);
      repeat (30) @(posedge clk_sys);
      rd(8'h04);
      check(st[14:12], 3'h0);
    end
    for (int k = 1; k <= 4; k++) begin
      faults <= 4'h1;
      waitMode(k < 4 ? OMC_SAFE : OMC_LATCH);
      if (k < 4) check(st[14:12], k);
      faults <= 4'h0;
      if (k < 4) waitMode(OMC_ACTIVE);
    end
    latchOut();
  endtask : testSafe
  initial begin
    {rst_n, wdFailPulse, wdServedPulse, wdFaultDrive, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, faults, pd} = '0;
    s_axi_wstrb = 4'hf;
    pd.devExitThreshold = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    testStart();
    testDevWd();
    testLowPower(2'h3);
    testLowPower(2'h1);
    testLowPower(2'h2);
    testSafe();
    stop_test();
  end
endmodule : test_omc_mode_ctrl
